// ==== rtl/bto_pkg.sv ====
// Constants shared by the tone output block and its helpers.
// Assumes a single 50 MHz system clock and AXI4-Lite register access.
package bto_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [5:0] PIN_FUNC_IDX = 6'h0a; // Pin function select two
	localparam logic [5:0] TONE_MODE_IDX = 6'h2e; // Tone mode control
	localparam logic [5:0] TONE_STAT_IDX = 6'h30; // Tone status, read only

	// Byte addresses on the register bus
	localparam logic [7:0] PIN_FUNC_ADDR = {PIN_FUNC_IDX, 2'h0};
	localparam logic [7:0] TONE_MODE_ADDR = {TONE_MODE_IDX, 2'h0};
	localparam logic [7:0] TONE_STAT_ADDR = {TONE_STAT_IDX, 2'h0};

	// Values after reset
	localparam logic [3:0] PIN_FUNC_RST = 4'h0;
	localparam logic [3:0] TONE_MODE_RST = 4'h0;

	// Field positions in the mode register
	localparam int MODE_DIV_LO = 0; // Division select, low bit
	localparam int MODE_SEL = 1; // Timer select or division high bit
	localparam int MODE_PULSE = 2; // One selects divided clock output
	localparam int MODE_EN = 3; // Divided clock output enable

	// Field position in the pin function register
	localparam int PF_TONE = 2; // One hands the shared pin to the tone

	// Shortest divided clock period in system clocks; each step doubles
	localparam logic [8:0] DIV_BASE = 9'h020;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/bto_toggle.sv ====
// Toggle unit: flips its level on each overflow of the chosen timer.
// Assumes overflow strobes are one-cycle pulses on the same clock.
`timescale 1ns/10ps
module bto_toggle (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic enable, // Toggle mode is selected and routed
	input wire logic sel_c, // Zero picks timer B, one timer C
	input wire logic ovf_b, // Timer B overflow strobe
	input wire logic ovf_c, // Timer C overflow strobe
	output logic level // Toggle waveform level
);

	logic trig; // Selected overflow event

	// Pick the overflow source
	assign trig = sel_c ? ovf_c : ovf_b;

	// Invert the level on each selected overflow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= 1'b0;
		end else if (enable && trig) begin
			level <= ~level;
		end
	end

endmodule

// ==== rtl/bto_pulse_gen.sv ====
// Divided clock pulse generator with gating at period boundaries.
// Assumes the enable and division select come from registers on aclk.
`timescale 1ns/10ps
module bto_pulse_gen (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic enable, // Pulse output enable bit
	input wire logic [1:0] div_sel, // Division ratio select
	output logic pulse, // Divided clock pulse train
	output logic gate, // Enable latched for the current period
	output logic period_end, // Last cycle of a period
	output logic [8:0] half_len // High time of the running period
);

	logic [7:0] cnt_r; // Position inside the period
	logic [1:0] sel_q_r; // Ratio latched for the current period
	logic [8:0] period; // Period length in clocks
	logic [7:0] last; // Final count of the period

	// Period length for a select value
	function automatic logic [8:0] period_of(input logic [1:0] s);
		return bto_pkg::DIV_BASE << s;
	endfunction

	// Period follows the latched ratio so a pulse never changes width
	assign period = period_of(sel_q_r);
	assign last = 8'(period - 9'h001);
	assign half_len = {1'b0, period[8:1]};
	assign period_end = (cnt_r == last);
	assign pulse = gate && ({1'b0, cnt_r} < half_len);

	// Period counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 8'h00;
		end else if (period_end) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Enable and ratio take effect only at a period boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate <= 1'b0;
			sel_q_r <= 2'h0;
		end else if (period_end) begin
			gate <= enable;
			sel_q_r <= div_sel;
		end
	end

endmodule

// ==== rtl/bto_top.sv ====
// Tone output block: registers, pin routing and the AXI4-Lite slave.
// Assumes timer strobes and port logic on aclk; the pin input is async.
//
// Contract
// - Toggle mode: mode bit 1 picks timer.
// - Each selected overflow inverts the output level.
// - Pulse mode outputs divided clock, ratio bits 0-1.
// - Pulses emitted only while mode bit 3 set; a pulse already started still runs to full width.
// - Bit 3 cleared in pulse mode: pin low.
// - Pulse width fixed whenever bit 3 written.
// - Mode register is 4-bit, write only.
// - Reset clears mode register to zero.
// - Pin function register, 4-bit write only, routes pin.
// - Reset clears pin function register, port role.
`timescale 1ns/10ps
module bto_top (
	input wire logic aclk, // System clock, 50 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic ovf_timer_b, // Timer B overflow strobe
	input wire logic ovf_timer_c, // Timer C overflow strobe
	input wire logic port_data, // Ordinary port output data
	input wire logic port_dir, // Ordinary port direction, one drives
	input wire logic tone_output_pin_i, // Shared pin level
	output logic tone_output_pin_o, // Shared pin output level
	output logic tone_output_pin_oe, // Shared pin output enable
	output logic [3:0] pin_func_o // Pin function bits for port logic
);

	logic [3:0] mode_r; // Tone mode control
	logic [3:0] pf_r; // Pin function select two
	logic [7:0] awaddr_r; // Held write address
	logic aw_held_r; // Write address taken
	logic [3:0] wdata_r; // Held write data, low nibble
	logic wlane_r; // Low byte strobe of held data
	logic w_held_r; // Write data taken
	logic wr_go; // Both halves of a write present
	logic wr_mapped; // Held address is a register
	logic rd_go; // Read address taken this cycle
	logic pin_s1_r; // Pin synchroniser, first stage
	logic pin_s2_r; // Pin synchroniser, second stage
	logic tone_lvl; // Toggle waveform
	logic pulse_w; // Divided clock pulse
	logic gate_w; // Latched pulse enable
	logic per_end_w; // Period boundary
	logic [8:0] half_w; // Pulse high time
	logic tog_mode; // Toggle path active
	logic pin_nxt; // Next pin level
	logic oe_nxt; // Next pin enable
	logic [8:0] hi_cnt_r; // High cycles of the running pulse

	// Toggle unit
	bto_toggle u_toggle (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(tog_mode),
		.sel_c(mode_r[bto_pkg::MODE_SEL]),
		.ovf_b(ovf_timer_b),
		.ovf_c(ovf_timer_c),
		.level(tone_lvl)
	);

	// Divided clock generator
	bto_pulse_gen u_pulse (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(mode_r[bto_pkg::MODE_EN]),
		.div_sel({mode_r[bto_pkg::MODE_SEL], mode_r[bto_pkg::MODE_DIV_LO]}),
		.pulse(pulse_w),
		.gate(gate_w),
		.period_end(per_end_w),
		.half_len(half_w)
	);

	// Toggle mode needs bit 2 clear and the pin handed over
	assign tog_mode = !mode_r[bto_pkg::MODE_PULSE] && pf_r[bto_pkg::PF_TONE];

	// Pin source selection
	always_comb begin
		if (pf_r[bto_pkg::PF_TONE]) begin
			oe_nxt = 1'b1;
			if (mode_r[bto_pkg::MODE_PULSE]) begin
				pin_nxt = pulse_w;
			end else begin
				pin_nxt = tone_lvl;
			end
		end else begin
			// Port role keeps its own data and direction
			oe_nxt = port_dir;
			pin_nxt = port_data;
		end
	end

	// Pin output flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tone_output_pin_o <= 1'b0;
			tone_output_pin_oe <= 1'b0;
		end else begin
			tone_output_pin_o <= pin_nxt;
			tone_output_pin_oe <= oe_nxt;
		end
	end

	// Pin input synchroniser for the status register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= tone_output_pin_i;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 4'h0;
			wlane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata[3:0];
			wlane_r <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_mapped = (awaddr_r == bto_pkg::PIN_FUNC_ADDR) ||
		(awaddr_r == bto_pkg::TONE_MODE_ADDR) ||
		(awaddr_r == bto_pkg::TONE_STAT_ADDR);

	// Ready while nothing of that channel is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_bvalid &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_r && !s_axi_bvalid &&
				!(s_axi_wvalid && s_axi_wready);
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bto_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? bto_pkg::RESP_OKAY :
				bto_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Mode and pin function registers, cleared by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= bto_pkg::TONE_MODE_RST;
			pf_r <= bto_pkg::PIN_FUNC_RST;
		end else if (wr_go && wlane_r) begin
			if (awaddr_r == bto_pkg::TONE_MODE_ADDR) begin
				mode_r <= wdata_r;
			end
			if (awaddr_r == bto_pkg::PIN_FUNC_ADDR) begin
				pf_r <= wdata_r;
			end
		end
	end

	assign pin_func_o = pf_r;

	// Read channel; write-only registers read as zero
	assign rd_go = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= bto_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= bto_pkg::RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				case (s_axi_araddr)
					bto_pkg::TONE_STAT_ADDR: begin
						s_axi_rdata <= {28'h0000000, pin_s2_r, gate_w,
							tone_output_pin_oe, tone_output_pin_o};
					end
					bto_pkg::TONE_MODE_ADDR, bto_pkg::PIN_FUNC_ADDR: begin
						s_axi_rdata <= 32'h00000000;
					end
					default: begin
						s_axi_rresp <= bto_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Helper: count high cycles of the pulse train
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_cnt_r <= 9'h000;
		end else if (pulse_w) begin
			hi_cnt_r <= hi_cnt_r + 9'h001;
		end else begin
			hi_cnt_r <= 9'h000;
		end
	end

	// Checks
	sequence s_pf_write_on;
		wr_go && wlane_r && (awaddr_r == bto_pkg::PIN_FUNC_ADDR) &&
			wdata_r[bto_pkg::PF_TONE];
	endsequence

	sequence s_gate_off;
		per_end_w && !mode_r[bto_pkg::MODE_EN];
	endsequence

	a_toggle_flip: assert property (@(posedge aclk) disable iff (!aresetn)
		(tog_mode && (mode_r[1] ? ovf_timer_c : ovf_timer_b))
			|=> (tone_lvl != $past(tone_lvl)))
		else $error("tone did not flip on selected overflow");

	a_toggle_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
		(tog_mode && (mode_r[1] ? !ovf_timer_c : !ovf_timer_b))
			|=> $stable(tone_lvl))
		else $error("tone flipped on the other timer");

	a_pulse_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(pf_r[2] && mode_r[2]) |=> (tone_output_pin_o == $past(pulse_w)) &&
			tone_output_pin_oe)
		else $error("pin does not carry the divided clock");

	a_pulse_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(pulse_w) |-> $past(mode_r[3]))
		else $error("pulse started without enable");

	a_gate_low: assert property (@(posedge aclk) disable iff (!aresetn)
		s_gate_off ##1 (!per_end_w)[*2] |-> !pulse_w && !gate_w)
		else $error("pulse continues after enable cleared");

	a_pin_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(pf_r[2] && mode_r[2] && !gate_w) |=> !tone_output_pin_o)
		else $error("pin not low while pulses disabled");

	a_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(pulse_w) |-> (hi_cnt_r == half_w))
		else $error("pulse width differs from half period");

	a_mode_unread: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_go && (s_axi_araddr == bto_pkg::TONE_MODE_ADDR))
			|=> s_axi_rvalid && (s_axi_rdata == 32'h00000000))
		else $error("mode register read back its contents");

	a_reset_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> (mode_r == 4'h0) && (pf_r == 4'h0) &&
			!tone_output_pin_oe)
		else $error("registers not cleared by reset");

	a_pf_takes_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		s_pf_write_on |-> ##[1:2] tone_output_pin_oe)
		else $error("pin function write did not take the pin");

	a_port_role: assert property (@(posedge aclk) disable iff (!aresetn)
		!pf_r[2] |=> (tone_output_pin_o == $past(port_data)) &&
			(tone_output_pin_oe == $past(port_dir)))
		else $error("tone drives the pin in port role");

endmodule

// ==== testbench/bto_sounder_model.sv ====
// Sounder load model: watches the shared pin and measures its pulses.
// Assumes the pin is sampled on aclk and the sounder pulls the line low.
`timescale 1ns/10ps
module bto_sounder_model (
	input wire logic aclk, // System clock
	input wire logic pin // Resolved pin level
);
	int rises = 0; // Rising edges seen
	int hi_w = 0; // Width of the last high phase
	int per = 0; // Cycles between the last two rises
	int pc = 0; // Cycles since the last rise
	int hc = 0; // High cycles so far
	logic prev = 1'b0; // Pin level at the previous edge
	// Measure every pulse as it passes
	always @(posedge aclk) begin
		pc = pc + 1;
		if (pin === 1'b1 && prev === 1'b0) begin
			rises = rises + 1;
			per = pc;
			pc = 0;
			hc = 0;
		end
		if (pin === 1'b1) hc = hc + 1;
		if (pin === 1'b0 && prev === 1'b1) hi_w = hc;
		prev = pin;
	end
endmodule

// ==== testbench/buzzer_tone_output_test.sv ====
// Self-checking bench for the tone output block.
// Assumes the sounder model on the pin and an AXI4-Lite master here.
`timescale 1ns/10ps
module buzzer_tone_output_test;
	logic aclk = 1'b0; // System clock
	logic aresetn = 1'b0; // Reset, active low
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic ovf_timer_b = 1'b0, ovf_timer_c = 1'b0;
	logic port_data = 1'b0, port_dir = 1'b0;
	logic tone_output_pin_o, tone_output_pin_oe;
	logic [3:0] pin_func_o;
	logic [31:0] rd;
	// Wire level; the sounder pulls the line low when undriven
	wire tone_output_pin_i = tone_output_pin_oe ? tone_output_pin_o : 1'b0;
	int err_total = 0, n_compared = 0, cyc = 0;
	int tog = 0; // Expected toggle level

	bto_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ovf_timer_b, .ovf_timer_c, .port_data, .port_dir,
		.tone_output_pin_i, .tone_output_pin_o, .tone_output_pin_oe,
		.pin_func_o);
	bto_sounder_model buz_u (.aclk(aclk), .pin(tone_output_pin_i));

	// Clock of 20 ns
	always #10 aclk = ~aclk;

	// Hang guard
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			$display("mismatch %0t timeout reached", $time);
			end_sim();
		end
	end

	// Compare one value and count it
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		n_compared = n_compared + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("mismatch %0t %s got %h want %h", $time, m, g, e);
		end
	endtask

	// Bus write; address and data offered together
	task automatic axw(input logic [7:0] a, input logic [3:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {28'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask

	// Bus read
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// One-cycle overflow strobe on timer B (0) or C (1)
	task automatic pulse_ovf(input int t);
		@(posedge aclk);
		ovf_timer_b <= (t == 0);
		ovf_timer_c <= (t == 1);
		@(posedge aclk);
		ovf_timer_b <= 1'b0;
		ovf_timer_c <= 1'b0;
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		int t, p, r0;
		logic d, dr;
		void'($urandom(32'h5077));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// Port role: pin follows port data and direction
		for (int i = 0; i < 8; i++) begin
			d = 1'($urandom);
			dr = 1'($urandom);
			@(posedge aclk);
			port_data <= d;
			port_dir <= dr;
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			chk(32'(pin_func_o), 32'h0, "pin func reset");
			chk(32'(tone_output_pin_oe), 32'(dr), "port oe");
			chk(32'(tone_output_pin_i), 32'(d & dr), "port pin");
		end
		$display("test port role done");
		// Registers are write only; unmapped places refused
		axw(bto_pkg::PIN_FUNC_ADDR, 4'h4, rsp);
		chk(32'(rsp), 32'(bto_pkg::RESP_OKAY), "pf write");
		axw(bto_pkg::TONE_MODE_ADDR, 4'h2, rsp);
		axr(bto_pkg::PIN_FUNC_ADDR, rd, rsp);
		chk(rd, 32'h0, "pf read");
		axr(bto_pkg::TONE_MODE_ADDR, rd, rsp);
		chk(rd, 32'h0, "mode read");
		chk(32'(rsp), 32'(bto_pkg::RESP_OKAY), "mode rresp");
		axw(8'h04, 4'h1, rsp);
		chk(32'(rsp), 32'(bto_pkg::RESP_SLVERR), "unmapped wr");
		axr(8'h04, rd, rsp);
		chk(32'(rsp), 32'(bto_pkg::RESP_SLVERR), "unmapped rd");
		// Write with the low byte strobe off stores nothing
		@(posedge aclk);
		s_axi_wstrb <= 4'h0;
		axw(bto_pkg::PIN_FUNC_ADDR, 4'h0, rsp);
		s_axi_wstrb <= 4'hf;
		chk(32'(rsp), 32'(bto_pkg::RESP_OKAY), "no lane wr");
		chk(32'(pin_func_o), 32'h4, "pf value");
		$display("test registers done");
		// Toggle mode, timer C then timer B
		for (int s = 1; s >= 0; s--) begin
			axw(bto_pkg::TONE_MODE_ADDR, 4'(s << 1), rsp);
			for (int k = 0; k < 8; k++) begin
				t = $urandom % 2;
				pulse_ovf(t);
				if (t == s) tog = 1 - tog;
				repeat (3) @(posedge aclk);
				@(negedge aclk);
				chk(32'(tone_output_pin_i), 32'(tog), "toggle");
				chk(32'(tone_output_pin_oe), 32'h1, "tone oe");
			end
		end
		// Status: pin level, enable, gate off, synchronised pin
		axr(bto_pkg::TONE_STAT_ADDR, rd, rsp);
		chk(rd, 32'(tog * 9 + 2), "status toggle");
		$display("test toggle done");
		// Divided clock for every ratio, then stop in mid-pulse
		for (int s = 0; s < 4; s++) begin
			p = 32 << s;
			axw(bto_pkg::TONE_MODE_ADDR, 4'(4 | s), rsp);
			repeat (4) @(posedge aclk);
			axw(bto_pkg::TONE_MODE_ADDR, 4'(12 | s), rsp);
			r0 = buz_u.rises;
			for (int i = 0; i < 6 * p && buz_u.rises < r0 + 3; i++)
				@(posedge aclk);
			@(negedge aclk);
			chk(32'(buz_u.per), 32'(p), "period");
			chk(32'(buz_u.hi_w), 32'(p / 2), "high time");
			axr(bto_pkg::TONE_STAT_ADDR, rd, rsp);
			chk(32'(rd[2]), 32'h1, "gate on");
			r0 = buz_u.rises;
			for (int i = 0; i < 2 * p && buz_u.rises == r0; i++)
				@(posedge aclk);
			axw(bto_pkg::TONE_MODE_ADDR, 4'(4 | s), rsp);
			r0 = buz_u.rises;
			repeat (3 * p) @(posedge aclk);
			@(negedge aclk);
			chk(32'(buz_u.rises), 32'(r0), "no pulses");
			chk(32'(tone_output_pin_i), 32'h0, "held low");
			chk(32'(buz_u.hi_w), 32'(p / 2), "full width");
		end
		$display("test divided clock done");
		// Reset while pulses run clears both registers
		axw(bto_pkg::TONE_MODE_ADDR, 4'hc, rsp);
		repeat (400) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(32'(pin_func_o), 32'h0, "pf after reset");
		axw(bto_pkg::PIN_FUNC_ADDR, 4'h4, rsp);
		r0 = buz_u.rises;
		repeat (300) @(posedge aclk);
		@(negedge aclk);
		chk(32'(buz_u.rises), 32'(r0), "mode cleared");
		chk(32'(tone_output_pin_i), 32'h0, "level cleared");
		$display("test reset done");
		end_sim();
	end
endmodule
